// ==== design/atac_pkg.sv ====
// constants for the adc threshold and accumulator post-processing block
package atac_pkg;

  // ------------------------------------------------------------
  // register byte addresses
  // ------------------------------------------------------------
  localparam logic [31:0] ATAC_OFS_STATUS      = 32'hffff0500;
  localparam logic [31:0] ATAC_OFS_MASK        = 32'hffff0504;
  localparam logic [31:0] ATAC_OFS_CONTROL     = 32'hffff0508;
  localparam logic [31:0] ATAC_OFS_MODE        = 32'hffff050c;
  localparam logic [31:0] ATAC_OFS_CONFIG      = 32'hffff0510;
  localparam logic [31:0] ATAC_OFS_RES_LIMIT   = 32'hffff0534;
  localparam logic [31:0] ATAC_OFS_RES_COUNT   = 32'hffff0538;
  localparam logic [31:0] ATAC_OFS_MAG_TH      = 32'hffff053c;
  localparam logic [31:0] ATAC_OFS_EXC_LIMIT   = 32'hffff0540;
  localparam logic [31:0] ATAC_OFS_EXC_COUNT   = 32'hffff0544;
  localparam logic [31:0] ATAC_OFS_ACC         = 32'hffff0548;
  localparam logic [31:0] ATAC_OFS_ACC_TH      = 32'hffff054c;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [15:0] ATAC_RST_MAG_TH      = 16'h0000;
  localparam logic [7:0]  ATAC_RST_EXC_LIMIT   = 8'h01;
  localparam logic [7:0]  ATAC_RST_EXC_COUNT   = 8'h00;
  localparam logic [31:0] ATAC_RST_ACC         = 32'h00000000;
  localparam logic [31:0] ATAC_RST_ACC_TH      = 32'h00000000;
  localparam logic [15:0] ATAC_RST_RES_LIMIT   = 16'h0001;
  localparam logic [15:0] ATAC_RST_RES_COUNT   = 16'h0000;
  localparam logic [4:0]  ATAC_RST_CONFIG      = 5'h00;
  localparam logic [2:0]  ATAC_RST_STATUS      = 3'h0;
  localparam logic [2:0]  ATAC_RST_MASK        = 3'h0;
  localparam logic [7:0]  ATAC_RST_CONTROL     = 8'h00;
  localparam logic [7:0]  ATAC_RST_MODE        = 8'h00;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int ATAC_CFG_RCNT_EN  = 0;
  localparam int ATAC_CFG_CMP_LO   = 1;
  localparam int ATAC_CFG_CMP_HI   = 2;
  localparam int ATAC_CFG_ACC_EN   = 3;
  localparam int ATAC_CTL_TWOS     = 0;
  localparam int ATAC_STA_READY    = 0;
  localparam int ATAC_STA_CMP_TH   = 1;
  localparam int ATAC_STA_ACC_EX   = 2;
  localparam int ATAC_STA_W        = 3;

  // ------------------------------------------------------------
  // comparator behaviour, config bits 2:1
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    ATAC_CMP_OFF   = 2'b00,
    ATAC_CMP_DEC   = 2'b01,
    ATAC_CMP_CLR   = 2'b10,
    ATAC_CMP_CLR2  = 2'b11
  } atac_cmp_mode_t;

endpackage

// ==== design/atac_exceed_counter.sv ====
// magnitude comparator with threshold-exceeded counter
`timescale 1ns/100ps
module atac_exceed_counter #(
  parameter int RES_W = 24
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    res_valid,
  input  wire logic [RES_W-1:0]        res_data,
  input  wire logic                    twos_mode,
  input  wire logic [15:0]             mag_threshold,
  input  wire logic [7:0]              exc_limit,
  input  wire atac_pkg::atac_cmp_mode_t cmp_mode,
  output logic [7:0]                   exc_count,
  output logic                         limit_hit
);
  import atac_pkg::*;

  initial begin
    if (RES_W < 17) $error("result width must exceed the 16-bit threshold");
  end

  logic [7:0]       cnt_r;
  logic [7:0]       cnt_nxt;
  logic             hit_nxt;
  logic [RES_W-1:0] abs_val;
  logic [15:0]      mag;
  logic [15:0]      th;
  logic             above;

  // ------------------------------------------------------------
  // magnitude: top 16 bits of the result against the threshold
  // ------------------------------------------------------------
  always_comb begin
    abs_val = res_data;
    if (twos_mode && res_data[RES_W-1]) begin
      abs_val = (~res_data) + {{(RES_W-1){1'b0}}, 1'b1};
    end
    // twos complement drops the sign bit, so only 15 bits compare
    if (twos_mode) begin
      mag = {1'b0, abs_val[RES_W-2 -: 15]};
      th  = {1'b0, mag_threshold[14:0]};
    end else begin
      mag = abs_val[RES_W-1 -: 16];
      th  = mag_threshold;
    end
    above = (mag >= th);
  end

  // ------------------------------------------------------------
  // counter update
  // ------------------------------------------------------------
  always_comb begin
    cnt_nxt = cnt_r;
    hit_nxt = 1'b0;
    if (res_valid && (cmp_mode != ATAC_CMP_OFF)) begin
      if (above) begin
        if (cnt_r != 8'hff) begin
          cnt_nxt = cnt_r + 8'h01;
        end
      end else if (cmp_mode == ATAC_CMP_DEC) begin
        if (cnt_r != 8'h00) begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end else begin
        cnt_nxt = ATAC_RST_EXC_COUNT;
      end
      hit_nxt = (cnt_nxt == exc_limit);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= ATAC_RST_EXC_COUNT;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // hit is taken from the next count so the flag lands with the count update
  assign exc_count = cnt_r;
  assign limit_hit = hit_nxt;

endmodule

// ==== design/atac_top.sv ====
// adc result threshold comparator, accumulator and apb register file
//
// Behaviour
// - compare result magnitude against 16-bit threshold
// - unipolar uses bits 15:0, twos uses 14:0
// - count up when magnitude reaches threshold
// - below threshold decrement or clear count
// - 8-bit limit of readings before flag
// - flag set when count equals limit
// - comparator runs only when config enables it
// - 32-bit read-only running accumulator
// - accumulator cleared when disabled or reconfigured
// - flag when accumulator exceeds 32-bit threshold
// - accumulator flag interrupts only when unmasked
// - result counter wraps to zero at limit
// - config bit 0 enables result counter
// - control or mode write clears result counter
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/100ps
module atac_top #(
  parameter int RES_W = 24
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        res_valid,
  input  wire logic [RES_W-1:0] res_data,
  output logic             irq
);
  import atac_pkg::*;

  initial begin
    if (RES_W < 17 || RES_W > 32) $error("result width must be 17 to 32");
  end

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [15:0]          mag_th_r;
  logic [15:0]          mag_th_nxt;
  logic [7:0]           exc_limit_r;
  logic [7:0]           exc_limit_nxt;
  logic [31:0]          acc_r;
  logic [31:0]          acc_nxt;
  logic [31:0]          acc_th_r;
  logic [31:0]          acc_th_nxt;
  logic [15:0]          res_limit_r;
  logic [15:0]          res_limit_nxt;
  logic [15:0]          res_cnt_r;
  logic [15:0]          res_cnt_nxt;
  logic [4:0]           cfg_r;
  logic [4:0]           cfg_nxt;
  logic [7:0]           ctl_r;
  logic [7:0]           ctl_nxt;
  logic [7:0]           mode_r;
  logic [7:0]           mode_nxt;
  logic [ATAC_STA_W-1:0] sta_r;
  logic [ATAC_STA_W-1:0] sta_nxt;
  logic [ATAC_STA_W-1:0] msk_r;
  logic [ATAC_STA_W-1:0] msk_nxt;
  logic [31:0]          prdata_r;
  logic [31:0]          prdata_nxt;
  logic                 err_r;
  logic                 err_nxt;

  logic                 wr_en;
  logic                 setup;
  logic                 reconfig;
  logic [7:0]           exc_count;
  logic                 limit_hit;
  logic [31:0]          res_ext;
  logic                 acc_over;
  logic                 ready_ev;
  logic                 acc_ev;
  atac_cmp_mode_t       cmp_mode;

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  function automatic logic is_mapped(input logic [31:0] a);
    if (a == ATAC_OFS_STATUS) begin
      return 1'b1;
    end else if (a == ATAC_OFS_MASK) begin
      return 1'b1;
    end else if (a == ATAC_OFS_CONTROL) begin
      return 1'b1;
    end else if (a == ATAC_OFS_MODE) begin
      return 1'b1;
    end else if (a == ATAC_OFS_CONFIG) begin
      return 1'b1;
    end else if (a == ATAC_OFS_RES_LIMIT || a == ATAC_OFS_RES_COUNT) begin
      return 1'b1;
    end else if (a == ATAC_OFS_MAG_TH || a == ATAC_OFS_EXC_LIMIT) begin
      return 1'b1;
    end else if (a == ATAC_OFS_EXC_COUNT || a == ATAC_OFS_ACC) begin
      return 1'b1;
    end else if (a == ATAC_OFS_ACC_TH) begin
      return 1'b1;
    end else begin
      return 1'b0;
    end
  endfunction

  // read data is latched in the setup cycle so prdata comes from a flop
  assign setup  = psel && !penable;
  assign wr_en  = psel && penable && pwrite && !err_r;
  assign pready = 1'b1;
  assign pslverr = psel && penable && err_r;

  // ------------------------------------------------------------
  // comparator instance
  // ------------------------------------------------------------
  assign cmp_mode = atac_cmp_mode_t'(cfg_r[ATAC_CFG_CMP_HI:ATAC_CFG_CMP_LO]);

  atac_exceed_counter #(
    .RES_W (RES_W)
  ) u_exceed (
    .pclk          (pclk),
    .presetn       (presetn),
    .res_valid     (res_valid),
    .res_data      (res_data),
    .twos_mode     (ctl_r[ATAC_CTL_TWOS]),
    .mag_threshold (mag_th_r),
    .exc_limit     (exc_limit_r),
    .cmp_mode      (cmp_mode),
    .exc_count     (exc_count),
    .limit_hit     (limit_hit)
  );

  // ------------------------------------------------------------
  // software registers
  // ------------------------------------------------------------
  always_comb begin
    mag_th_nxt    = mag_th_r;
    exc_limit_nxt = exc_limit_r;
    acc_th_nxt    = acc_th_r;
    res_limit_nxt = res_limit_r;
    cfg_nxt       = cfg_r;
    ctl_nxt       = ctl_r;
    mode_nxt      = mode_r;
    msk_nxt       = msk_r;
    reconfig      = 1'b0;
    if (wr_en) begin
      if (paddr == ATAC_OFS_MAG_TH) begin
        mag_th_nxt = pwdata[15:0];
      end else if (paddr == ATAC_OFS_EXC_LIMIT) begin
        exc_limit_nxt = pwdata[7:0];
      end else if (paddr == ATAC_OFS_ACC_TH) begin
        acc_th_nxt = pwdata;
      end else if (paddr == ATAC_OFS_RES_LIMIT) begin
        res_limit_nxt = pwdata[15:0];
      end else if (paddr == ATAC_OFS_CONFIG) begin
        cfg_nxt = pwdata[4:0];
      end else if (paddr == ATAC_OFS_CONTROL) begin
        ctl_nxt  = pwdata[7:0];
        reconfig = 1'b1;
      end else if (paddr == ATAC_OFS_MODE) begin
        mode_nxt = pwdata[7:0];
        reconfig = 1'b1;
      end else if (paddr == ATAC_OFS_MASK) begin
        msk_nxt = pwdata[ATAC_STA_W-1:0];
      end
    end
  end

  // ------------------------------------------------------------
  // result counter and accumulator
  // ------------------------------------------------------------
  always_comb begin
    if (ctl_r[ATAC_CTL_TWOS]) begin
      res_ext = {{(32-RES_W){res_data[RES_W-1]}}, res_data};
    end else begin
      res_ext = {{(32-RES_W){1'b0}}, res_data};
    end
    res_cnt_nxt = res_cnt_r;
    acc_nxt     = acc_r;
    ready_ev    = 1'b0;
    acc_ev      = 1'b0;
    if (res_valid && cfg_r[ATAC_CFG_RCNT_EN]) begin
      if (res_cnt_r + 16'h0001 == res_limit_r) begin
        res_cnt_nxt = ATAC_RST_RES_COUNT;
        ready_ev    = 1'b1;
      end else begin
        res_cnt_nxt = res_cnt_r + 16'h0001;
      end
    end else if (res_valid) begin
      ready_ev = 1'b1;
    end
    if (res_valid && cfg_r[ATAC_CFG_ACC_EN]) begin
      acc_nxt = acc_r + res_ext;
      acc_ev  = 1'b1;
    end
    // reconfiguring wins over a result arriving in the same cycle
    if (reconfig) begin
      res_cnt_nxt = ATAC_RST_RES_COUNT;
      acc_nxt     = ATAC_RST_ACC;
      acc_ev      = 1'b0;
    end
    if (!cfg_r[ATAC_CFG_ACC_EN]) begin
      acc_nxt = ATAC_RST_ACC;
    end
  end

  // signed compare in twos mode so negative sums never look huge
  always_comb begin
    if (ctl_r[ATAC_CTL_TWOS]) begin
      acc_over = $signed(acc_nxt) > $signed(acc_th_r);
    end else begin
      acc_over = acc_nxt > acc_th_r;
    end
  end

  // ------------------------------------------------------------
  // status and interrupt; a set beats a same-cycle clear
  // ------------------------------------------------------------
  always_comb begin
    sta_nxt = sta_r;
    if (wr_en && paddr == ATAC_OFS_STATUS) begin
      sta_nxt = sta_r & ~pwdata[ATAC_STA_W-1:0];
    end
    if (ready_ev) begin
      sta_nxt[ATAC_STA_READY] = 1'b1;
    end
    if (limit_hit) begin
      sta_nxt[ATAC_STA_CMP_TH] = 1'b1;
    end
    if (acc_ev && acc_over) begin
      sta_nxt[ATAC_STA_ACC_EX] = 1'b1;
    end
  end

  assign irq = |(sta_r & msk_r);

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  always_comb begin
    prdata_nxt = prdata_r;
    err_nxt    = err_r;
    if (setup) begin
      err_nxt    = !is_mapped(paddr);
      prdata_nxt = 32'h00000000;
      if (paddr == ATAC_OFS_STATUS) begin
        prdata_nxt[ATAC_STA_W-1:0] = sta_r;
      end else if (paddr == ATAC_OFS_MASK) begin
        prdata_nxt[ATAC_STA_W-1:0] = msk_r;
      end else if (paddr == ATAC_OFS_CONTROL) begin
        prdata_nxt[7:0] = ctl_r;
      end else if (paddr == ATAC_OFS_MODE) begin
        prdata_nxt[7:0] = mode_r;
      end else if (paddr == ATAC_OFS_CONFIG) begin
        prdata_nxt[4:0] = cfg_r;
      end else if (paddr == ATAC_OFS_RES_LIMIT) begin
        prdata_nxt[15:0] = res_limit_r;
      end else if (paddr == ATAC_OFS_RES_COUNT) begin
        prdata_nxt[15:0] = res_cnt_r;
      end else if (paddr == ATAC_OFS_MAG_TH) begin
        prdata_nxt[15:0] = mag_th_r;
      end else if (paddr == ATAC_OFS_EXC_LIMIT) begin
        prdata_nxt[7:0] = exc_limit_r;
      end else if (paddr == ATAC_OFS_EXC_COUNT) begin
        prdata_nxt[7:0] = exc_count;
      end else if (paddr == ATAC_OFS_ACC) begin
        prdata_nxt = acc_r;
      end else if (paddr == ATAC_OFS_ACC_TH) begin
        prdata_nxt = acc_th_r;
      end
    end
  end

  assign prdata = prdata_r;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mag_th_r    <= ATAC_RST_MAG_TH;
      exc_limit_r <= ATAC_RST_EXC_LIMIT;
      acc_r       <= ATAC_RST_ACC;
      acc_th_r    <= ATAC_RST_ACC_TH;
      res_limit_r <= ATAC_RST_RES_LIMIT;
      res_cnt_r   <= ATAC_RST_RES_COUNT;
      cfg_r       <= ATAC_RST_CONFIG;
      ctl_r       <= ATAC_RST_CONTROL;
      mode_r      <= ATAC_RST_MODE;
      sta_r       <= ATAC_RST_STATUS;
      msk_r       <= ATAC_RST_MASK;
      prdata_r    <= 32'h00000000;
      err_r       <= 1'b0;
    end else begin
      mag_th_r    <= mag_th_nxt;
      exc_limit_r <= exc_limit_nxt;
      acc_r       <= acc_nxt;
      acc_th_r    <= acc_th_nxt;
      res_limit_r <= res_limit_nxt;
      res_cnt_r   <= res_cnt_nxt;
      cfg_r       <= cfg_nxt;
      ctl_r       <= ctl_nxt;
      mode_r      <= mode_nxt;
      sta_r       <= sta_nxt;
      msk_r       <= msk_nxt;
      prdata_r    <= prdata_nxt;
      err_r       <= err_nxt;
    end
  end

endmodule

// ==== verif/atac_chk.sv ====
// assertion checker for the adc threshold and accumulator block
`timescale 1ns/100ps
module atac_chk
  import atac_pkg::*;
#(
  parameter int RES_W = 24
) (
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [31:0]      paddr,
  input wire logic [31:0]      pwdata,
  input wire logic [31:0]      prdata,
  input wire logic             pready,
  input wire logic             pslverr,
  input wire logic             res_valid,
  input wire logic [RES_W-1:0] res_data,
  input wire logic             irq
);
  logic mapped;
  logic acc_rd;

  assign mapped = paddr inside {ATAC_OFS_STATUS, ATAC_OFS_MASK, ATAC_OFS_CONTROL, ATAC_OFS_MODE,
                                ATAC_OFS_CONFIG, ATAC_OFS_RES_LIMIT, ATAC_OFS_RES_COUNT,
                                ATAC_OFS_MAG_TH, ATAC_OFS_EXC_LIMIT, ATAC_OFS_EXC_COUNT,
                                ATAC_OFS_ACC, ATAC_OFS_ACC_TH};
  assign acc_rd = psel && penable && !pwrite;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ------------------------------------------------------------
  // bus answer
  // ------------------------------------------------------------
  a_ready_always: assert property (pready) else $error("pready low");
  a_slverr_phase: assert property (pslverr |-> psel && penable) else $error("error outside access");
  a_unmapped_err: assert property (psel && penable && !mapped |-> pslverr)
    else $error("unmapped access without error");
  a_mapped_ok: assert property (psel && penable && mapped |-> !pslverr)
    else $error("mapped access flagged");
  a_unmapped_zero: assert property (acc_rd && !mapped |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  // read data may only move after a setup edge, so a read stays coherent
  a_rdata_setup: assert property ($changed(prdata) |-> $past(psel && !penable))
    else $error("read data moved outside setup");

  // ------------------------------------------------------------
  // narrow registers
  // ------------------------------------------------------------
  a_cnt_width: assert property (acc_rd && paddr == ATAC_OFS_EXC_COUNT |-> prdata[31:8] == 24'h0)
    else $error("exceed counter wider than 8 bits");
  a_th_width: assert property (acc_rd && paddr == ATAC_OFS_MAG_TH |-> prdata[31:16] == 16'h0)
    else $error("threshold wider than 16 bits");

  // ------------------------------------------------------------
  // interrupt line
  // ------------------------------------------------------------
  a_irq_cause: assert property ($rose(irq) |->
    $past(res_valid) || $past(res_valid, 2) || $past(psel && penable && pwrite))
    else $error("irq rose without cause");
  a_irq_clear: assert property ($fell(irq) |-> $past(psel && penable && pwrite))
    else $error("irq fell without a write");
endmodule

bind atac_top atac_chk #(.RES_W(RES_W)) u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .res_valid, .res_data, .irq);

// ==== verif/atac_res_src.sv ====
// model of the primary converter result path
`timescale 1ns/100ps
module atac_res_src #(
  parameter int RES_W = 24
) (
  input wire logic         pclk,
  output logic             res_valid,
  output logic [RES_W-1:0] res_data
);
  initial begin
    res_valid = 1'b0;
    res_data  = '0;
  end

  // one-cycle result pulse; data is scrambled afterwards so a late sample is caught
  task automatic send(input logic [RES_W-1:0] v);
    @(posedge pclk);
    res_valid <= 1'b1;
    res_data  <= v;
    @(posedge pclk);
    res_valid <= 1'b0;
    res_data  <= ~v;
  endtask
endmodule

// ==== verif/tb.sv ====
// self-checking testbench for the adc threshold and accumulator block
`timescale 1ns/100ps
module tb;
  import atac_pkg::*;
  localparam int RW = 24;
  localparam logic [23:0] HI = 24'h010000;
  localparam logic [23:0] LO = 24'h00ff00;
  localparam logic [31:0] RA [10] = '{ATAC_OFS_STATUS, ATAC_OFS_MASK, ATAC_OFS_CONFIG,
    ATAC_OFS_RES_LIMIT, ATAC_OFS_RES_COUNT, ATAC_OFS_MAG_TH, ATAC_OFS_EXC_LIMIT,
    ATAC_OFS_EXC_COUNT, ATAC_OFS_ACC, ATAC_OFS_ACC_TH};
  localparam logic [31:0] RV [10] = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h0, 32'h0, 32'h1,
    32'h0, 32'h0, 32'h0};

  logic          pclk;
  logic          presetn;
  logic          psel;
  logic          penable;
  logic          pwrite;
  logic [31:0]   paddr;
  logic [31:0]   pwdata;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  logic          res_valid;
  logic [RW-1:0] res_data;
  logic          irq;
  logic [31:0]   rdat;
  logic          rerr;
  int            err_total = 0;
  int            total_checks = 0;
  int            cyc = 0;

  // starts unknown, so the first half period ends on a rising edge
  always #10 pclk = (pclk !== 1'b1);

  atac_top #(.RES_W(RW)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .res_valid(res_valid), .res_data(res_data), .irq(irq));
  atac_res_src #(.RES_W(RW)) u_src (.pclk(pclk), .res_valid(res_valid), .res_data(res_data));

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // the sequence runs about 800 cycles; the 20000-cycle ceiling leaves wide margin
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      final_report();
    end
  end

  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic chk_w(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      $display("FAIL %s expected %h seen %h", n, e, g);
      err_total++;
    end
  endtask

  task automatic chk_b(input string n, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      $display("FAIL %s expected %b seen %b", n, e, g);
      err_total++;
    end
  endtask

  task automatic rdc(input string n, input logic [31:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk_w(n, e, rdat);
  endtask

  task automatic sts(input int b, input logic e);
    apb(1'b0, ATAC_OFS_STATUS, 32'h0);
    chk_b("status bit", e, rdat[b]);
  endtask

  task automatic irq_is(input logic e);
    @(negedge pclk);
    chk_b("irq", e, irq);
  endtask

  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 32'h0;
    pwdata  = 32'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 10; i++) rdc("reset value", RA[i], RV[i]);
    $display("test reset done");

    wr(ATAC_OFS_EXC_COUNT, 32'hff);
    wr(ATAC_OFS_ACC, 32'hffffffff);
    rdc("ro counter", ATAC_OFS_EXC_COUNT, 32'h0);
    rdc("ro accumulator", ATAC_OFS_ACC, 32'h0);
    wr(ATAC_OFS_MAG_TH, 32'hffffabcd);
    rdc("threshold", ATAC_OFS_MAG_TH, 32'h0000abcd);
    wr(ATAC_OFS_EXC_LIMIT, 32'h1ff);
    rdc("limit", ATAC_OFS_EXC_LIMIT, 32'hff);
    wr(32'hffff0550, 32'h1);
    chk_b("unmapped write error", 1'b1, rerr);
    rdc("unmapped read", 32'hffff0550, 32'h0);
    chk_b("unmapped read error", 1'b1, rerr);
    $display("test access done");

    wr(ATAC_OFS_CONFIG, 32'h2);
    wr(ATAC_OFS_MAG_TH, 32'h0100);
    wr(ATAC_OFS_EXC_LIMIT, 32'h3);
    wr(ATAC_OFS_STATUS, 32'h7);
    u_src.send(HI);
    u_src.send(HI);
    rdc("count", ATAC_OFS_EXC_COUNT, 32'h2);
    sts(ATAC_STA_CMP_TH, 1'b0);
    u_src.send(HI);
    rdc("count", ATAC_OFS_EXC_COUNT, 32'h3);
    sts(ATAC_STA_CMP_TH, 1'b1);
    u_src.send(LO);
    rdc("count dec", ATAC_OFS_EXC_COUNT, 32'h2);
    wr(ATAC_OFS_CONFIG, 32'h4);
    u_src.send(HI);
    u_src.send(LO);
    rdc("count clr", ATAC_OFS_EXC_COUNT, 32'h0);
    wr(ATAC_OFS_CONFIG, 32'h2);
    u_src.send(LO);
    rdc("count floor", ATAC_OFS_EXC_COUNT, 32'h0);
    wr(ATAC_OFS_CONFIG, 32'h0);
    u_src.send(HI);
    rdc("count off", ATAC_OFS_EXC_COUNT, 32'h0);
    wr(ATAC_OFS_CONFIG, 32'h2);
    repeat (260) u_src.send(HI);
    rdc("count top", ATAC_OFS_EXC_COUNT, 32'hff);
    $display("test comparator done");

    wr(ATAC_OFS_CONTROL, 32'h1);
    wr(ATAC_OFS_MAG_TH, 32'h8123);
    wr(ATAC_OFS_CONFIG, 32'h6);
    u_src.send(24'hfede00);
    rdc("twos below", ATAC_OFS_EXC_COUNT, 32'h0);
    u_src.send(24'hfedc00);
    rdc("twos negative", ATAC_OFS_EXC_COUNT, 32'h1);
    u_src.send(24'h012400);
    rdc("twos bit15 unused", ATAC_OFS_EXC_COUNT, 32'h2);
    u_src.send(24'h012300);
    rdc("twos equal", ATAC_OFS_EXC_COUNT, 32'h3);
    $display("test twos done");

    wr(ATAC_OFS_CONFIG, 32'h8);
    wr(ATAC_OFS_ACC_TH, 32'h100);
    wr(ATAC_OFS_MASK, 32'h0);
    wr(ATAC_OFS_STATUS, 32'h7);
    u_src.send(24'hffff00);
    rdc("acc signed", ATAC_OFS_ACC, 32'hffffff00);
    sts(ATAC_STA_ACC_EX, 1'b0);
    u_src.send(24'h000300);
    sts(ATAC_STA_READY, 1'b1);
    rdc("acc sum", ATAC_OFS_ACC, 32'h200);
    sts(ATAC_STA_ACC_EX, 1'b1);
    irq_is(1'b0);
    wr(ATAC_OFS_MASK, 32'h4);
    irq_is(1'b1);
    wr(ATAC_OFS_STATUS, 32'h4);
    irq_is(1'b0);
    wr(ATAC_OFS_CONFIG, 32'h0);
    rdc("acc disabled", ATAC_OFS_ACC, 32'h0);
    wr(ATAC_OFS_CONFIG, 32'h8);
    u_src.send(24'h000010);
    wr(ATAC_OFS_MODE, 32'h0);
    rdc("acc reconfig", ATAC_OFS_ACC, 32'h0);
    wr(ATAC_OFS_CONTROL, 32'h0);
    u_src.send(24'hffff00);
    rdc("acc unsigned", ATAC_OFS_ACC, 32'h00ffff00);
    irq_is(1'b1);
    $display("test accumulator done");

    wr(ATAC_OFS_MASK, 32'h1);
    wr(ATAC_OFS_CONFIG, 32'h1);
    wr(ATAC_OFS_RES_LIMIT, 32'h3);
    wr(ATAC_OFS_MODE, 32'h0);
    wr(ATAC_OFS_STATUS, 32'h7);
    u_src.send(HI);
    u_src.send(HI);
    rdc("res count", ATAC_OFS_RES_COUNT, 32'h2);
    sts(ATAC_STA_READY, 1'b0);
    u_src.send(HI);
    rdc("res wrap", ATAC_OFS_RES_COUNT, 32'h0);
    irq_is(1'b1);
    u_src.send(HI);
    wr(ATAC_OFS_CONTROL, 32'h0);
    rdc("res clear", ATAC_OFS_RES_COUNT, 32'h0);
    wr(ATAC_OFS_CONFIG, 32'h0);
    u_src.send(HI);
    rdc("res off", ATAC_OFS_RES_COUNT, 32'h0);
    $display("test result counter done");
    final_report();
  end
endmodule
